// *** debounce_pkg.sv ***
// Purpose: Shared constants for the switch debouncer
// Assumes: 20 MHz core clock
// Notes: Times kept in their own unit, counts derived here
package debounce_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int QUAL_TIME_MS = 40;
   localparam int SAMPLE_HZ = 1000;
   localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
   localparam int QUAL_COUNT_DEFAULT = (QUAL_TIME_MS * SAMPLE_HZ + 999) / 1000;
   localparam int CNT_W = 16;
   localparam int DIV_W = 16;
   localparam logic [7:0] LEVELS_RESET = 8'hff;
   localparam logic FLAG_RESET = 1'b1;
endpackage : debounce_pkg

// *** octal_switch_debouncer.sv ***
// Purpose: Debounce one, two or eight contact inputs with change flag and output gate
// Assumes: Contact inputs and gate are asynchronous pins; supply monitor gives a level
// Notes: Sample tick from a divider of core_clk; outputs as value plus enable
//
// Summary of operation
// - An output keeps its level until its input holds the opposite level for 40 ms.
// - Any sample where input equals output clears that channel counter.
// - A counter reaching full count loads the sampled input into the output.
// - The change flag asserts in the same update as the new output level.
// - The change flag goes low on a state change and stays low until the gate clears it.
// - Outputs are driven only while the gate is low, else left undriven.
// - Gate low clears the change flag high and holds it high while low.
// - Below the lockout threshold synchronised inputs pass straight through.
`timescale 1ns/100ps
module octal_switch_debouncer
   import debounce_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int SAMPLE_DIVIDE = SAMPLE_DIV,
   parameter int QUAL_COUNT = QUAL_COUNT_DEFAULT
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [CHANNELS-1:0] raw_contact_bits,
   input wire logic gate_n,
   input wire logic undervolt,
   output logic [CHANNELS-1:0] clean_levels,
   output logic [CHANNELS-1:0] clean_levels_oe,
   output logic state_moved_flag_n
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [CHANNELS-1:0] in_s1;
      logic [CHANNELS-1:0] in_s2;
      logic [CHANNELS-1:0] in_s3;
      logic [2:0] gate_sync;
      logic [2:0] uv_sync;
      logic gate_n;
      logic uv;
      logic [DIV_W-1:0] div;
      logic tick;
      logic [CHANNELS-1:0][CNT_W-1:0] cnt;
      logic [CHANNELS-1:0] level;
      logic [CHANNELS-1:0] oe;
      logic flag_n;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [CHANNELS-1:0] in_q;
   logic [CHANNELS-1:0] moved;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      state_next = state_reg;
      moved = '0;
      state_next.in_s1 = raw_contact_bits;
      state_next.in_s2 = state_reg.in_s1;
      state_next.in_s3 = state_reg.in_s2;
      state_next.gate_sync = {state_reg.gate_sync[1:0], gate_n};
      state_next.uv_sync = {state_reg.uv_sync[1:0], undervolt};
      if (state_reg.gate_sync[2] == state_reg.gate_sync[1]) begin
         state_next.gate_n = state_reg.gate_sync[1];
      end
      if (state_reg.uv_sync[2] == state_reg.uv_sync[1]) begin
         state_next.uv = state_reg.uv_sync[1];
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (state_reg.in_s3[i] == state_reg.in_s2[i]) begin
            in_q[i] = state_reg.in_s2[i];
         end else begin
            in_q[i] = state_reg.level[i];
         end
      end
      // Shared sample divider
      state_next.tick = 1'b0;
      if (state_reg.div == DIV_W'(SAMPLE_DIVIDE - 1)) begin
         state_next.div = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.div = state_reg.div + DIV_W'(1);
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (state_reg.uv) begin
            state_next.level[i] = in_q[i];
            state_next.cnt[i] = '0;
         end else if (state_reg.tick) begin
            if (in_q[i] == state_reg.level[i]) begin
               state_next.cnt[i] = '0;
            end else if (state_reg.cnt[i] == CNT_W'(QUAL_COUNT - 1)) begin
               state_next.level[i] = in_q[i];
               state_next.cnt[i] = '0;
               moved[i] = 1'b1;
            end else begin
               state_next.cnt[i] = state_reg.cnt[i] + CNT_W'(1);
            end
         end
      end
      state_next.oe = {CHANNELS{~state_reg.gate_n}};
      if (!state_reg.gate_n) begin
         state_next.flag_n = 1'b1;
      end else if (|moved) begin
         state_next.flag_n = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '0;
         state_reg.in_s1 <= LEVELS_RESET[CHANNELS-1:0];
         state_reg.in_s2 <= LEVELS_RESET[CHANNELS-1:0];
         state_reg.in_s3 <= LEVELS_RESET[CHANNELS-1:0];
         state_reg.level <= LEVELS_RESET[CHANNELS-1:0];
         state_reg.gate_sync <= 3'h7;
         state_reg.gate_n <= 1'b1;
         state_reg.flag_n <= FLAG_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign clean_levels = state_reg.level;
   assign clean_levels_oe = state_reg.oe;
   assign state_moved_flag_n = state_reg.flag_n;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence gate_low_seen;
      !state_reg.gate_n;
   endsequence

   AST_GATE_CLEARS_FLAG: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      gate_low_seen |=> state_moved_flag_n)
      else $error("flag not cleared by gate");

   AST_OE_FOLLOWS_GATE: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state_reg.gate_n |=> (clean_levels_oe == '0))
      else $error("outputs driven with gate high");

   AST_OE_ON_GATE_LOW: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      !state_reg.gate_n |=> (clean_levels_oe == '1))
      else $error("outputs not driven with gate low");

   AST_FLAG_ON_CHANGE: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      ($past(state_reg.gate_n) && !$past(state_reg.uv) && $changed(clean_levels))
      |-> !state_moved_flag_n)
      else $error("flag missed output change");

   AST_FLAG_STICKY: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (!state_moved_flag_n && state_reg.gate_n) |=> !state_moved_flag_n)
      else $error("flag released without gate");

   AST_FLAG_CAUSE: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      $fell(state_moved_flag_n) |-> $past(|moved))
      else $error("flag fell without change");

   AST_HOLD_NO_TICK: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (!state_reg.uv && !state_reg.tick) |=> $stable(clean_levels))
      else $error("output moved off sample");

   AST_CNT_CLEAR: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (state_reg.tick && !state_reg.uv && in_q[0] == state_reg.level[0])
      |=> state_reg.cnt[0] == '0)
      else $error("counter not cleared");

   AST_LOAD_AT_FULL: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (state_reg.tick && !state_reg.uv && in_q[0] != state_reg.level[0]
       && state_reg.cnt[0] == CNT_W'(QUAL_COUNT - 1))
      |=> clean_levels[0] == $past(in_q[0]))
      else $error("qualified level not loaded");

   AST_UV_TRANSPARENT: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state_reg.uv |=> clean_levels == $past(in_q))
      else $error("lockout not transparent");

   sequence early_mismatch_tick;
      state_reg.tick && !state_reg.uv && (in_q[0] != state_reg.level[0])
      && (state_reg.cnt[0] != CNT_W'(QUAL_COUNT - 1));
   endsequence

   AST_CNT_STEP: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      early_mismatch_tick |=> state_reg.cnt[0] == $past(state_reg.cnt[0]) + CNT_W'(1))
      else $error("counter did not advance");

   AST_HOLD_BEFORE_FULL: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      early_mismatch_tick |=> clean_levels[0] == $past(state_reg.level[0]))
      else $error("output moved before full count");

   AST_CNT_BOUND: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state_reg.cnt[0] < CNT_W'(QUAL_COUNT))
      else $error("counter beyond full count");

   AST_TICK_SINGLE: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      state_reg.tick |=> !state_reg.tick)
      else $error("sample tick longer than one cycle");

   AST_UV_NO_FLAG: assert property (
      @(posedge core_clk) disable iff (!arst_n)
      (state_reg.uv && state_moved_flag_n) |=> state_moved_flag_n)
      else $error("flag set during lockout");

endmodule : octal_switch_debouncer

// *** mcu_poll_model.sv ***
// Purpose: Processor polling the debouncer over its data bus
// Assumes: Gate driven at the falling edge
// Notes: Reports flag seen before the gate, then the bus value read
`timescale 1ns/100ps
module mcu_poll_model (
   input wire logic core_clk,
   input wire logic poll_req,
   input wire logic [7:0] clean_levels,
   input wire logic [7:0] clean_levels_oe,
   input wire logic state_moved_flag_n,
   output logic gate_n,
   output logic rd_valid,
   output logic [8:0] rd_data
);
   initial begin
      int i;
      gate_n = 1'b1;
      rd_valid = 1'b0;
      rd_data = 9'h000;
      forever begin
         @(negedge core_clk);
         rd_valid = 1'b0;
         if (poll_req) begin
            rd_data[8] = state_moved_flag_n;
            gate_n = 1'b0;
            @(negedge core_clk);
            for (i = 0; i < 20 && clean_levels_oe !== 8'hff; i++) @(negedge core_clk);
            // Undriven bus lines read inverted
            rd_data[7:0] = ~(clean_levels ^ clean_levels_oe);
            rd_valid = 1'b1;
            gate_n = 1'b1;
            @(negedge core_clk);
            rd_valid = 1'b0;
            // Wait for the bus to be released
            for (i = 0; i < 20 && clean_levels_oe !== 8'h00; i++) @(negedge core_clk);
         end
      end
   end
endmodule : mcu_poll_model

// *** octal_switch_debouncer_test.sv ***
// Purpose: Self-checking bench for the switch debouncer
// Assumes: Shortened divider and qualification count
// Notes: Expected reads queued, compared when the processor reports
`timescale 1ns/100ps
module octal_switch_debouncer_test;
   import debounce_pkg::*;
   logic core_clk, arst_n, gate_n, undervolt, poll_req, rd_valid, flag_n;
   logic [7:0] raw, lv, oe, v, cur;
   logic [8:0] rd_data, e;
   logic [8:0] exp_q[$];
   logic [31:0] seed = 32'hcce6;
   int n_fail = 0;
   int checks_done = 0;
   octal_switch_debouncer #(.CHANNELS(8), .SAMPLE_DIVIDE(4), .QUAL_COUNT(3)) uut (
      .core_clk(core_clk), .arst_n(arst_n), .raw_contact_bits(raw), .gate_n(gate_n),
      .undervolt(undervolt), .clean_levels(lv), .clean_levels_oe(oe),
      .state_moved_flag_n(flag_n));
   mcu_poll_model mcu (.core_clk(core_clk), .poll_req(poll_req), .clean_levels(lv),
      .clean_levels_oe(oe), .state_moved_flag_n(flag_n), .gate_n(gate_n),
      .rd_valid(rd_valid), .rd_data(rd_data));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic poll(input logic [7:0] lev, input logic fl);
      int i;
      exp_q.push_back({fl, lev});
      poll_req <= 1'b1;
      for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(posedge core_clk);
      if (i == 40) begin
         n_fail++;
         $display("MISMATCH poll_answer exp 1 got 0");
      end
      @(negedge core_clk);
      poll_req <= 1'b0;
      repeat (6) @(negedge core_clk);
   endtask : poll
   task automatic wrap_up;
      if (exp_q.size() != 0) n_fail++;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      if (rd_valid === 1'b1) begin
         checks_done++;
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("MISMATCH flag_and_levels exp none got %h", rd_data);
         end else begin
            e = exp_q.pop_front();
            if (rd_data !== e) begin
               n_fail++;
               $display("MISMATCH flag_and_levels exp %h got %h", e, rd_data);
            end
         end
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end
   initial begin
      arst_n = 1'b0;
      raw = 8'hff;
      cur = 8'hff;
      undervolt = 1'b0;
      poll_req = 1'b0;
      repeat (3) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      poll(LEVELS_RESET, FLAG_RESET);
      repeat (6) begin
         seed = xs(seed);
         v = seed[7:0];
         raw = v;
         repeat (40) @(negedge core_clk);
         poll(v, v == cur);
         poll(v, 1'b1);
         repeat (3) begin
            raw = ~v;
            repeat (6) @(negedge core_clk);
            raw = v;
            repeat (6) @(negedge core_clk);
         end
         repeat (34) @(negedge core_clk);
         poll(v, 1'b1);
         cur = v;
      end
      undervolt = 1'b1;
      raw = ~cur;
      repeat (8) @(negedge core_clk);
      poll(~cur, 1'b1);
      wrap_up();
   end
endmodule : octal_switch_debouncer_test
